// File: test_usb_endpoint_tx_rx_fifo.sv
// bench for the endpoint fifo block: register accesses plus endpoint controller traffic
// assumes the fifo block, its package and the endpoint model are compiled first
module test_usb_endpoint_tx_rx_fifo;
    timeunit 1ns;
    timeprecision 1ns;
    import uef_pkg::*;
    logic                 core_clk = 1'b0;
    logic                 rst_b    = 1'b0;
    uef_axi_req_t         req      = '0;
    uef_axi_rsp_t         rsp;
    uef_ep_req_t          ep_req;
    logic [23:0]          tx_byte;
    logic [2:0]           tx_empty;
    logic [2:0]           rx_full;
    logic                 irq;
    logic [31:0]          rdat;
    logic [1:0]           resp;
    int                   fail_count  = 0;
    int                   check_count = 0;
    int                   cyc         = 0;
    uef_endpoint_fifo uut (.core_clk(core_clk), .rst_b(rst_b), .axi_req(req), .axi_rsp(rsp), .ep_req(ep_req),
                           .tx_byte(tx_byte), .tx_empty(tx_empty), .rx_full(rx_full), .irq(irq));
    uef_ep_model ep (.core_clk(core_clk), .ep_req(ep_req));
    always #50 core_clk = ~core_clk;
    task automatic conclude();
        if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // hang guard, far beyond the roughly six hundred cycles the sequence needs
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // handshakes are judged at the rising edge, seeing the values that stood just before it
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        aw = 1'b1;
        w  = 1'b1;
        @(posedge core_clk);
        req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hF, bready: 1'b1, default: '0};
        while (aw || w) begin
            @(posedge core_clk);
            if (aw && rsp.awready) begin
                aw = 1'b0;
                req.awvalid <= 1'b0;
            end
            if (w && rsp.wready) begin
                w = 1'b0;
                req.wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk); while (!rsp.bvalid);
        resp = rsp.bresp;
        req.bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a);
        @(posedge core_clk);
        req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
        do @(posedge core_clk); while (!rsp.arready);
        req.arvalid <= 1'b0;
        do @(posedge core_clk); while (!rsp.rvalid);
        rdat = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
    endtask
    task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
        axi_read(a);
        chk(rdat, exp);
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        read_check(8'h60, 32'h7);
        read_check(8'h08, 32'd32);
        read_check(8'h28, 32'd64);
        read_check(8'h38, 32'd0);
        axi_write(8'h64, 32'h1);
        @(negedge core_clk);
        chk({31'h0, irq}, 32'h1);
        axi_write(8'h00, 32'hA0);
        axi_write(8'h00, 32'hA1);
        axi_read(8'h60);
        read_check(8'h60, 32'h6);
        @(negedge core_clk);
        chk({31'h0, irq}, 32'h0);
        chk({24'h0, tx_byte[7:0]}, 32'hA0);
        ep.take(0);
        repeat (2) @(negedge core_clk);
        chk({24'h0, tx_byte[7:0]}, 32'hA1);
        read_check(8'h08, 32'd31);
        axi_write(8'h04, 32'h200);
        read_check(8'h08, 32'd32);
        // one byte more than fits; the extra one must be dropped
        for (int i = 0; i < 33; i++) axi_write(8'h00, 32'(64 + i));
        read_check(8'h08, 32'd0);
        for (int i = 0; i < 32; i++) begin
            repeat (2) @(negedge core_clk);
            chk({24'h0, tx_byte[7:0]}, 32'(64 + i));
            ep.take(0);
        end
        @(negedge core_clk);
        chk({31'h0, tx_empty[0]}, 32'h1);
        ep.take(0);
        read_check(8'h08, 32'h120);
        axi_write(8'h08, 32'h100);
        read_check(8'h08, 32'h20);
        axi_write(8'h04, 32'h100);
        ep.take(0);
        read_check(8'h08, 32'h20);
        for (int i = 0; i < 64; i++) ep.store(2, 8'(i));
        read_check(8'h58, 32'd64);
        @(negedge core_clk);
        chk({29'h0, rx_full}, 32'h4);
        ep.store(2, 8'hFF);
        read_check(8'h58, 32'h140);
        read_check(8'h60, 32'h47);
        for (int i = 0; i < 64; i++) read_check(8'h50, 32'(i));
        read_check(8'h50, 32'd63);
        read_check(8'h58, 32'h100);
        ep.store(2, 8'h5A);
        axi_write(8'h54, 32'h200);
        read_check(8'h58, 32'h100);
        axi_write(8'h58, 32'h100);
        read_check(8'h58, 32'h0);
        axi_write(8'h68, 32'h0);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        axi_read(8'h6C);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        conclude();
    end
endmodule

// File: uef_endpoint_fifo.sv
// endpoint transmit and receive fifos with an axi4-lite register port
// assumes the endpoint controller runs on core_clk and pulses one take/store per byte
// How it works
// - tx fifos let firmware refill while a long packet goes out.
// - tx read pointer steps once per byte taken, wraps at size.
// - tx read pointer never passes the tx write pointer.
// - take from empty tx fifo without last flag flags underrun.
// - tx write pointer steps once per firmware write, wraps at size.
// - firmware write into full tx fifo is dropped untouched.
// - tx warning set while tx level is at or below threshold.
// - tx status shows free bytes, size minus level.
// - rx fifos let firmware drain while a long packet comes in.
// - rx read pointer steps per firmware read, wraps, never passes write.
// - read from empty rx fifo repeats last byte, pointer held.
// - rx write pointer steps per byte stored, wraps at size.
// - store into full rx fifo flags overrun.
// - rx warning set while free space is at or below threshold.
// - rx status shows bytes available, size minus level.
// - flush resets both pointers of that fifo.
// - depths are 32, 32 and 64 bytes per direction.
module uef_endpoint_fifo (
    input  wire logic                  core_clk,
    input  wire logic                  rst_b,
    input  wire uef_pkg::uef_axi_req_t axi_req,
    output uef_pkg::uef_axi_rsp_t      axi_rsp,
    input  wire uef_pkg::uef_ep_req_t  ep_req,
    output logic [3*8-1:0]             tx_byte,
    output logic [2:0]                 tx_empty,
    output logic [2:0]                 rx_full,
    output logic                       irq
);
    import uef_pkg::*;

    localparam int SIZES_TX [3] = '{TX_FIFO_SIZE_0, TX_FIFO_SIZE_1, TX_FIFO_SIZE_2};
    localparam int SIZES_RX [3] = '{RX_FIFO_SIZE_0, RX_FIFO_SIZE_1, RX_FIFO_SIZE_2};

    // advance a wrap-bit pointer; position wraps at size, wrap bit toggles
    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p, input int size);
        logic [PTR_W-2:0] pos;
        pos = p[PTR_W-2:0];
        if (int'(pos) == size - 1)
            ptr_inc = {~p[PTR_W-1], {(PTR_W-1){1'b0}}};
        else
            ptr_inc = {p[PTR_W-1], pos + (PTR_W-1)'(1)};
    endfunction

    // bytes held between two wrap-bit pointers
    function automatic logic [PTR_W-1:0] ptr_level(input logic [PTR_W-1:0] w,
                                                    input logic [PTR_W-1:0] r, input int size);
        logic [PTR_W-1:0] d;
        d = {1'b0, w[PTR_W-2:0]} - {1'b0, r[PTR_W-2:0]};
        if (w[PTR_W-1] != r[PTR_W-1])
            ptr_level = d + PTR_W'(size);
        else
            ptr_level = d;
    endfunction

    logic [7:0]       tx_mem_0 [TX_FIFO_SIZE_0];
    logic [7:0]       tx_mem_1 [TX_FIFO_SIZE_1];
    logic [7:0]       tx_mem_2 [TX_FIFO_SIZE_2];
    logic [7:0]       rx_mem_0 [RX_FIFO_SIZE_0];
    logic [7:0]       rx_mem_1 [RX_FIFO_SIZE_1];
    logic [7:0]       rx_mem_2 [RX_FIFO_SIZE_2];
    logic [PTR_W-1:0] tx_read_ptr_reg  [3];
    logic [PTR_W-1:0] tx_write_ptr_reg [3];
    logic [PTR_W-1:0] rx_read_ptr_reg  [3];
    logic [PTR_W-1:0] rx_write_ptr_reg [3];
    logic [6:0]       tx_warning_threshold_reg [3];
    logic [6:0]       rx_warning_threshold_reg [3];
    logic [2:0]       tx_last_reg;
    logic [2:0]       tx_underrun_reg;
    logic [2:0]       rx_overrun_reg;
    logic [6:0]       warn_event_reg;
    logic [6:0]       warn_mask_reg;
    logic [7:0]       rx_last_byte_reg [3];
    logic [PTR_W-1:0] tx_level [3];
    logic [PTR_W-1:0] tx_free_count [3];
    logic [PTR_W-1:0] rx_avail_count [3];
    logic [PTR_W-1:0] rx_level [3];
    logic [2:0]       tx_warning_flag;
    logic [2:0]       rx_warning_flag;
    logic [2:0]       tx_is_full;
    logic [2:0]       rx_is_empty;
    logic [PTR_W-1:0] tx_show_ptr [3];

    // axi write and read channel state
    logic             aw_held_reg;
    logic             w_held_reg;
    logic [7:0]       aw_addr_reg;
    logic [31:0]      w_data_reg;
    logic [3:0]       w_strb_reg;
    logic             bvalid_reg;
    logic [1:0]       bresp_reg;
    logic             rvalid_reg;
    logic [31:0]      rdata_reg;
    logic [1:0]       rresp_reg;
    logic             wr_fire;
    logic             rd_fire;
    logic [2:0]       wr_tx_data;
    logic [2:0]       wr_tx_cmd;
    logic [2:0]       wr_tx_sta;
    logic [2:0]       wr_rx_cmd;
    logic [2:0]       wr_rx_sta;
    logic [2:0]       rd_rx_data;
    logic [2:0]       tx_flush;
    logic [2:0]       rx_flush;
    logic             rd_event;
    logic [2:0]       tx_take_ok;
    logic [2:0]       rx_store_ok;

    // levels and counts per fifo
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            tx_level[i]       = ptr_level(tx_write_ptr_reg[i], tx_read_ptr_reg[i], SIZES_TX[i]);
            tx_free_count[i]  = PTR_W'(SIZES_TX[i]) - tx_level[i];
            rx_avail_count[i] = ptr_level(rx_write_ptr_reg[i], rx_read_ptr_reg[i], SIZES_RX[i]);
            rx_level[i]       = PTR_W'(SIZES_RX[i]) - rx_avail_count[i];
            tx_warning_flag[i] = tx_level[i] <= {1'b0, tx_warning_threshold_reg[i][5:0]} ||
                                 (tx_warning_threshold_reg[i][6] && tx_level[i] <= PTR_W'(64));
            rx_warning_flag[i] = rx_level[i] <= tx_pad(rx_warning_threshold_reg[i]);
            tx_is_full[i]  = tx_level[i] == PTR_W'(SIZES_TX[i]);
            rx_is_empty[i] = rx_write_ptr_reg[i] == rx_read_ptr_reg[i];
            tx_empty[i]    = tx_write_ptr_reg[i] == tx_read_ptr_reg[i];
            rx_full[i]     = rx_level[i] == '0;
            tx_take_ok[i]  = ep_req.tx_take[i] && !tx_empty[i];
            rx_store_ok[i] = ep_req.rx_store[i] && !rx_full[i];
            // byte the controller sees next; a flush points it back at slot zero at once
            tx_show_ptr[i] = tx_take_ok[i] ? ptr_inc(tx_read_ptr_reg[i], SIZES_TX[i]) : tx_read_ptr_reg[i];
            if (tx_flush[i])
                tx_show_ptr[i] = '0;
        end
    end

    function automatic logic [PTR_W-1:0] tx_pad(input logic [6:0] t);
        tx_pad = t;
    endfunction

    // axi-lite handshakes: address and data taken in either order
    assign wr_fire = (aw_held_reg || axi_req.awvalid) && (w_held_reg || axi_req.wvalid) && !bvalid_reg;
    assign rd_fire = axi_req.arvalid && !rvalid_reg;
    assign axi_rsp.awready = !aw_held_reg && !bvalid_reg;
    assign axi_rsp.wready  = !w_held_reg && !bvalid_reg;
    assign axi_rsp.arready = !rvalid_reg;
    assign axi_rsp.bvalid  = bvalid_reg;
    assign axi_rsp.bresp   = bresp_reg;
    assign axi_rsp.rvalid  = rvalid_reg;
    assign axi_rsp.rdata   = rdata_reg;
    assign axi_rsp.rresp   = rresp_reg;

    logic [7:0]  wa;
    logic [31:0] wd;
    logic        wlane0;
    logic        wlane1;
    assign wa     = aw_held_reg ? aw_addr_reg : axi_req.awaddr;
    assign wd     = w_held_reg ? w_data_reg : axi_req.wdata;
    assign wlane0 = w_held_reg ? w_strb_reg[0] : axi_req.wstrb[0];
    assign wlane1 = w_held_reg ? w_strb_reg[1] : axi_req.wstrb[1];

    // write and rx data read address decode per fifo
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            wr_tx_data[i] = wr_fire && wlane0 && wa == OFS_TX_DATA + 8'(i) * OFS_FIFO_STEP;
            wr_tx_cmd[i]  = wr_fire && wa == OFS_TX_CMD + 8'(i) * OFS_FIFO_STEP;
            wr_tx_sta[i]  = wr_fire && wlane1 && wa == OFS_TX_STATUS + 8'(i) * OFS_FIFO_STEP;
            wr_rx_cmd[i]  = wr_fire && wa == OFS_RX_CMD + 8'(i) * OFS_FIFO_STEP;
            wr_rx_sta[i]  = wr_fire && wlane1 && wa == OFS_RX_STATUS + 8'(i) * OFS_FIFO_STEP;
            rd_rx_data[i] = rd_fire && axi_req.araddr == OFS_RX_DATA + 8'(i) * OFS_FIFO_STEP;
            tx_flush[i]   = wr_tx_cmd[i] && wlane1 && wd[CMD_FLUSH_BIT];
            rx_flush[i]   = wr_rx_cmd[i] && wlane1 && wd[CMD_FLUSH_BIT];
        end
    end
    assign rd_event = rd_fire && axi_req.araddr == OFS_WARN_EVENT;

    // write channel holding and response
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= (wa > OFS_WARN_MASK || wa[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
            end else begin
                if (axi_req.awvalid && axi_rsp.awready) begin
                    aw_held_reg <= 1'b1;
                    aw_addr_reg <= axi_req.awaddr;
                end
                if (axi_req.wvalid && axi_rsp.wready) begin
                    w_held_reg <= 1'b1;
                    w_data_reg <= axi_req.wdata;
                    w_strb_reg <= axi_req.wstrb;
                end
                if (bvalid_reg && axi_req.bready)
                    bvalid_reg <= 1'b0;
            end
        end
    end

    // read channel: one cycle after arvalid the data is presented
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
            for (int i = 0; i < 3; i++) begin
                if (axi_req.araddr == OFS_TX_CMD + 8'(i) * OFS_FIFO_STEP)
                    rdata_reg <= {23'h0, tx_last_reg[i], 1'b0, tx_warning_threshold_reg[i]};
                if (axi_req.araddr == OFS_TX_STATUS + 8'(i) * OFS_FIFO_STEP)
                    rdata_reg <= {23'h0, tx_underrun_reg[i], 1'b0, tx_free_count[i]};
                if (axi_req.araddr == OFS_RX_CMD + 8'(i) * OFS_FIFO_STEP)
                    rdata_reg <= {25'h0, rx_warning_threshold_reg[i]};
                if (axi_req.araddr == OFS_RX_STATUS + 8'(i) * OFS_FIFO_STEP)
                    rdata_reg <= {23'h0, rx_overrun_reg[i], 1'b0, rx_avail_count[i]};
                if (rd_rx_data[i])
                    rdata_reg <= rx_is_empty[i] ? {24'h0, rx_last_byte_reg[i]} : {24'h0, rx_peek(i)};
            end
            if (axi_req.araddr == OFS_WARN_EVENT)
                rdata_reg <= {25'h0, warn_event_reg};
            else if (axi_req.araddr == OFS_WARN_MASK)
                rdata_reg <= {25'h0, warn_mask_reg};
            if (axi_req.araddr > OFS_WARN_MASK || axi_req.araddr[1:0] != 2'h0)
                rresp_reg <= RESP_SLVERR;
        end else if (rvalid_reg && axi_req.rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    function automatic logic [7:0] rx_peek(input int i);
        case (i)
            0:       rx_peek = rx_mem_0[rx_read_ptr_reg[0][4:0]];
            1:       rx_peek = rx_mem_1[rx_read_ptr_reg[1][4:0]];
            default: rx_peek = rx_mem_2[rx_read_ptr_reg[2][5:0]];
        endcase
    endfunction

    // pointer updates; flush wins over any step in the same cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 3; i++) begin
                tx_read_ptr_reg[i]  <= '0;
                tx_write_ptr_reg[i] <= '0;
                rx_read_ptr_reg[i]  <= '0;
                rx_write_ptr_reg[i] <= '0;
                rx_last_byte_reg[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (tx_flush[i]) begin
                    tx_read_ptr_reg[i]  <= '0;
                    tx_write_ptr_reg[i] <= '0;
                end else begin
                    if (tx_take_ok[i])
                        tx_read_ptr_reg[i] <= ptr_inc(tx_read_ptr_reg[i], SIZES_TX[i]);
                    if (wr_tx_data[i] && !tx_is_full[i])
                        tx_write_ptr_reg[i] <= ptr_inc(tx_write_ptr_reg[i], SIZES_TX[i]);
                end
                if (rx_flush[i]) begin
                    rx_read_ptr_reg[i]  <= '0;
                    rx_write_ptr_reg[i] <= '0;
                end else begin
                    if (rd_rx_data[i] && !rx_is_empty[i]) begin
                        rx_read_ptr_reg[i]  <= ptr_inc(rx_read_ptr_reg[i], SIZES_RX[i]);
                        rx_last_byte_reg[i] <= rx_peek(i);
                    end
                    if (rx_store_ok[i])
                        rx_write_ptr_reg[i] <= ptr_inc(rx_write_ptr_reg[i], SIZES_RX[i]);
                end
            end
        end
    end

    // byte storage, no reset needed for data arrays
    always_ff @(posedge core_clk) begin
        if (wr_tx_data[0] && !tx_is_full[0]) tx_mem_0[tx_write_ptr_reg[0][4:0]] <= wd[7:0];
        if (wr_tx_data[1] && !tx_is_full[1]) tx_mem_1[tx_write_ptr_reg[1][4:0]] <= wd[7:0];
        if (wr_tx_data[2] && !tx_is_full[2]) tx_mem_2[tx_write_ptr_reg[2][5:0]] <= wd[7:0];
        if (rx_store_ok[0]) rx_mem_0[rx_write_ptr_reg[0][4:0]] <= ep_req.rx_byte;
        if (rx_store_ok[1]) rx_mem_1[rx_write_ptr_reg[1][4:0]] <= ep_req.rx_byte;
        if (rx_store_ok[2]) rx_mem_2[rx_write_ptr_reg[2][5:0]] <= ep_req.rx_byte;
    end

    // byte presented to the controller; data output from flops
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            tx_byte <= 24'h00_0000;
        else begin
            tx_byte[7:0]   <= tx_mem_0[tx_show_ptr[0][4:0]];
            tx_byte[15:8]  <= tx_mem_1[tx_show_ptr[1][4:0]];
            tx_byte[23:16] <= tx_mem_2[tx_show_ptr[2][5:0]];
        end
    end

    // command registers: thresholds, last flag, sticky error flags
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 3; i++) begin
                tx_warning_threshold_reg[i] <= THR_RESET;
                rx_warning_threshold_reg[i] <= THR_RESET;
            end
            tx_last_reg     <= 3'h0;
            tx_underrun_reg <= 3'h0;
            rx_overrun_reg  <= 3'h0;
            warn_mask_reg   <= 7'h00;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (wr_tx_cmd[i] && wlane0) tx_warning_threshold_reg[i] <= wd[6:0];
                if (wr_rx_cmd[i] && wlane0) rx_warning_threshold_reg[i] <= wd[6:0];
                if (wr_tx_cmd[i] && wlane1) tx_last_reg[i] <= wd[CMD_LAST_BIT];
                // set wins over the clear so no event is lost
                if (ep_req.tx_take[i] && tx_empty[i] && !tx_last_reg[i])
                    tx_underrun_reg[i] <= 1'b1;
                else if (wr_tx_sta[i] && wd[STA_ERR_BIT])
                    tx_underrun_reg[i] <= 1'b0;
                if (ep_req.rx_store[i] && rx_full[i])
                    rx_overrun_reg[i] <= 1'b1;
                else if (wr_rx_sta[i] && wd[STA_ERR_BIT])
                    rx_overrun_reg[i] <= 1'b0;
            end
            if (wr_fire && wlane0 && wa == OFS_WARN_MASK)
                warn_mask_reg <= wd[6:0];
        end
    end

    // warning events: sticky, cleared by reading the event register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            warn_event_reg <= 7'h00;
        else
            warn_event_reg <= (rd_event ? 7'h00 : warn_event_reg) |
                              {rx_warning_flag, 1'b0, tx_warning_flag};
    end

    assign irq = |(warn_event_reg & warn_mask_reg);

    // checks
    a_tx_ptr_step: assert property (@(posedge core_clk) disable iff (!rst_b)
        tx_take_ok[0] && !tx_flush[0] |=> tx_read_ptr_reg[0] == ptr_inc($past(tx_read_ptr_reg[0]), 32))
        else $error("tx read pointer did not step");
    a_tx_no_pass: assert property (@(posedge core_clk) disable iff (!rst_b)
        tx_level[2] <= PTR_W'(64) && tx_level[0] <= PTR_W'(32))
        else $error("tx level out of range");
    a_tx_underrun: assert property (@(posedge core_clk) disable iff (!rst_b)
        ep_req.tx_take[0] && tx_empty[0] && !tx_last_reg[0] |=> tx_underrun_reg[0])
        else $error("underrun not latched");
    a_tx_full_drop: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr_tx_data[0] && tx_is_full[0] && !tx_take_ok[0] && !tx_flush[0] |=> $stable(tx_write_ptr_reg[0]))
        else $error("write into full fifo moved pointer");
    a_tx_free_cnt: assert property (@(posedge core_clk) disable iff (!rst_b)
        tx_empty[0] |-> tx_free_count[0] == PTR_W'(TX_FIFO_SIZE_0))
        else $error("tx free count wrong");
    a_rx_empty_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        rd_rx_data[2] && rx_is_empty[2] && !rx_flush[2] |=> $stable(rx_read_ptr_reg[2]))
        else $error("empty read moved pointer");
    a_rx_overrun: assert property (@(posedge core_clk) disable iff (!rst_b)
        ep_req.rx_store[2] && rx_full[2] |=> rx_overrun_reg[2])
        else $error("overrun not latched");
    a_flush_ptrs: assert property (@(posedge core_clk) disable iff (!rst_b)
        rx_flush[2] |=> rx_avail_count[2] == '0 && rx_read_ptr_reg[2] == '0)
        else $error("flush left data");
    a_rx_warn_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        rx_warning_flag[2] && !rd_event |=> warn_event_reg[EV_RX_LSB + 2])
        else $error("rx warning not set");
endmodule

// File: uef_ep_model.sv
// endpoint controller model: takes tx bytes and stores rx bytes, one pulse per byte
// assumes core_clk is shared with the fifo block; the bench calls the tasks in order
module uef_ep_model (
    input  wire logic            core_clk,
    output uef_pkg::uef_ep_req_t ep_req
);
    import uef_pkg::*;
    // quiet at time zero so no spurious take or store reaches the fifos
    initial ep_req = '0;
    // one take pulse, drained while firmware may still be refilling
    task automatic take(input int i);
        @(posedge core_clk);
        ep_req.tx_take[i] <= 1'b1;
        @(posedge core_clk);
        ep_req.tx_take[i] <= 1'b0;
    endtask
    // one store pulse; the byte lane flips afterwards so a stale value is never read twice
    task automatic store(input int i, input logic [7:0] b);
        @(posedge core_clk);
        ep_req.rx_store[i] <= 1'b1;
        ep_req.rx_byte     <= b;
        @(posedge core_clk);
        ep_req.rx_store[i] <= 1'b0;
        ep_req.rx_byte     <= ~b;
    endtask
endmodule

// File: uef_pkg.sv
// package for the endpoint fifo block: register map, field layout, bus carriers
// assumes an axi4-lite master on the register side and one clock for everything
package uef_pkg;
    // fifo sizes (bytes), tx1/tx2/tx3 and rx1/rx2/rx3
    localparam int TX_FIFO_SIZE_0 = 32;
    localparam int TX_FIFO_SIZE_1 = 32;
    localparam int TX_FIFO_SIZE_2 = 64;
    localparam int RX_FIFO_SIZE_0 = 32;
    localparam int RX_FIFO_SIZE_1 = 32;
    localparam int RX_FIFO_SIZE_2 = 64;
    localparam int NUM_FIFO       = 3;
    localparam int PTR_W          = 7;     // 6 position bits plus a wrap bit
    // register byte offsets; per-fifo registers step by 0x10
    localparam logic [7:0] OFS_TX_DATA    = 8'h00;
    localparam logic [7:0] OFS_TX_CMD     = 8'h04;
    localparam logic [7:0] OFS_TX_STATUS  = 8'h08;
    localparam logic [7:0] OFS_RX_DATA    = 8'h30;
    localparam logic [7:0] OFS_RX_CMD     = 8'h34;
    localparam logic [7:0] OFS_RX_STATUS  = 8'h38;
    localparam logic [7:0] OFS_FIFO_STEP  = 8'h10;
    localparam logic [7:0] OFS_WARN_EVENT = 8'h60;
    localparam logic [7:0] OFS_WARN_MASK  = 8'h64;
    // command register fields
    localparam int CMD_THR_LSB   = 0;    // threshold [6:0]
    localparam int CMD_LAST_BIT  = 8;    // tx last-byte flag
    localparam int CMD_FLUSH_BIT = 9;    // write 1 to flush, self-clearing
    // status register fields
    localparam int STA_CNT_LSB   = 0;    // free / available count [6:0]
    localparam int STA_ERR_BIT   = 8;    // underrun or overrun, cleared by write 1
    // warning event layout: tx in [2:0], rx in [6:4]
    localparam int EV_RX_LSB     = 4;
    localparam logic [6:0] THR_RESET = 7'h00;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // axi4-lite slave carriers
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } uef_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } uef_axi_rsp_t;

    // endpoint controller side, one take and one store lane per fifo, one rx byte shared by all
    typedef struct packed {
        logic [NUM_FIFO-1:0] tx_take;      // controller takes a tx byte
        logic [NUM_FIFO-1:0] rx_store;     // controller stores an rx byte
        logic [7:0]          rx_byte;
    } uef_ep_req_t;
endpackage
